// file: rtl/acc_consts.svh
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// Register offsets
`define ACC_OFS_X_LSB 8'h02
`define ACC_OFS_TEMP 8'h08
`define ACC_OFS_RANGE 8'h0F
`define ACC_OFS_BW 8'h10
`define ACC_OFS_LP_CTL 8'h11
`define ACC_OFS_LP_MODE 8'h12
`define ACC_OFS_DATA_CTL 8'h13
`define ACC_OFS_SELFTEST 8'h32

// Field positions
`define ACC_LP_EN_BIT 6
`define ACC_SLEEP_HI 4
`define ACC_SLEEP_LO 1
`define ACC_LP_VAR_BIT 6
`define ACC_UNFILT_BIT 7
`define ACC_SHDIS_BIT 6
`define ACC_ST_AXIS_HI 1
`define ACC_ST_AXIS_LO 0
`define ACC_ST_SIGN_BIT 2
`define ACC_ST_AMP_BIT 4
`define ACC_NEW_BIT 0

// Reset values
`define ACC_RANGE_RST 4'h3
`define ACC_BW_RST 5'h0F

// Bandwidth decoding
`define ACC_BW_LOW_IDX 3'h0
`define ACC_BW_HIGH_IDX 3'h7

// Timing: base unit is the 0.5 ms step, at 100 MHz
`define ACC_CLK_MHZ 100
`define ACC_UNIT_US 500
`define ACC_UNIT_CYC (`ACC_UNIT_US * `ACC_CLK_MHZ)
`define ACC_SETTLE_US 10
`define ACC_SETTLE_CYC (`ACC_SETTLE_US * `ACC_CLK_MHZ)

// Sleep durations in 0.5 ms steps
`define ACC_SLP_0_5MS 11'h001
`define ACC_SLP_1MS 11'h002
`define ACC_SLP_2MS 11'h004
`define ACC_SLP_4MS 11'h008
`define ACC_SLP_6MS 11'h00C
`define ACC_SLP_10MS 11'h014
`define ACC_SLP_25MS 11'h032
`define ACC_SLP_50MS 11'h064
`define ACC_SLP_100MS 11'h0C8
`define ACC_SLP_500MS 11'h3E8
`define ACC_SLP_1S 11'h7D0

`endif

// file: rtl/acc_pkg.sv
`default_nettype none

package acc_pkg;

   typedef struct packed {
      logic [11:0] z;
      logic [11:0] y;
      logic [11:0] x;
   } acc_sample_t;

   typedef struct packed {
      logic amp;
      logic sign;
      logic [1:0] axis;
   } acc_selftest_t;

   typedef enum logic [3:0] {
      ACC_NORMAL = 4'h1,
      ACC_SLEEP = 4'h2,
      ACC_SETTLE = 4'h4,
      ACC_ACQ = 4'h8
   } acc_state_t;

endpackage

`default_nettype wire

// file: rtl/acc_readout.sv
// How it works
// - Sleep code 0000-0101 gives 0.5 ms; higher codes step up to 1 s.
// - Analog powered while awake, off in sleep; settle time before sampling.
// - Each axis sample is 12-bit two's complement.
// - Bits 11:4 in upper byte; bits 3:0 plus fresh flag in lower byte.
// - Lower-byte read freezes upper byte until host reads upper byte.
// - Shadow-disable bit 1 turns freezing off; samples then update both bytes.
// - Fresh flag sets on every update, clears on reading either byte.
// - Unfiltered rate 2 kHz; filtered rate twice the bandwidth.
// - Select bit 0 stores filtered data, 1 stores unfiltered data.
// - Bandwidth codes 01000-01111 give 7.81 Hz to 1000 Hz, 64 ms to 0.5 ms.
// - Codes 00xxx act as 7.81 Hz, codes 1xxxx as 1000 Hz.
// - Range codes 0011, 0101, 1000, 1100 select 2, 4, 8, 16 g.
// - LSB weight follows range: 0.98, 1.95, 3.91, 7.81 mg.
// - Die temperature readable as 8-bit two's complement register.
// - Temperature 0.5 K per LSB, zero means 23 degrees C.
// - Self-test axis field: 01 x, 10 y, 11 z, 00 off.
// - Self-test sign 0 deflects negative, 1 positive.
// - Low-power enable bit enters or leaves; variant bit picks mode 1 or 2.
`timescale 1ns/1ps
`include "acc_consts.svh"
`default_nettype none

module acc_readout #(
   parameter int P_UNIT_CYC = `ACC_UNIT_CYC,
   parameter int P_SETTLE_CYC = `ACC_SETTLE_CYC
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // Register port
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Sensing front end
   input wire acc_pkg::acc_sample_t i_afe_filt,
   input wire acc_pkg::acc_sample_t i_afe_raw,
   input wire logic [7:0] i_afe_temp,
   output logic o_analog_pwr,
   output logic o_lp_variant,
   output logic [3:0] o_range,
   output logic [2:0] o_bw_idx,
   output acc_pkg::acc_selftest_t o_selftest
);

   function automatic logic [2:0] bw_index(input logic [4:0] code);
      if (code[4])
         bw_index = `ACC_BW_HIGH_IDX;
      else if (!code[3])
         bw_index = `ACC_BW_LOW_IDX;
      else
         bw_index = code[2:0];
   endfunction

   function automatic logic [10:0] sleep_units(input logic [3:0] code);
      case (code)
         4'h6: sleep_units = `ACC_SLP_1MS;
         4'h7: sleep_units = `ACC_SLP_2MS;
         4'h8: sleep_units = `ACC_SLP_4MS;
         4'h9: sleep_units = `ACC_SLP_6MS;
         4'hA: sleep_units = `ACC_SLP_10MS;
         4'hB: sleep_units = `ACC_SLP_25MS;
         4'hC: sleep_units = `ACC_SLP_50MS;
         4'hD: sleep_units = `ACC_SLP_100MS;
         4'hE: sleep_units = `ACC_SLP_500MS;
         4'hF: sleep_units = `ACC_SLP_1S;
         default: sleep_units = `ACC_SLP_0_5MS;
      endcase
   endfunction

   localparam int UW = $clog2(P_UNIT_CYC + 1);
   localparam int SW = $clog2(P_SETTLE_CYC + 1);

   logic [3:0] range_q;
   logic [4:0] bw_q;
   logic lp_en_q;
   logic [3:0] sleep_code_q;
   logic lp_var_q;
   logic unfilt_q;
   logic shdis_q;
   acc_pkg::acc_selftest_t st_q;
   logic [7:0] temp_q;
   logic [7:0] msb_q [3];
   logic [3:0] lsb_q [3];
   logic new_q [3];
   logic lock_q [3];
   acc_pkg::acc_state_t state_q;
   acc_pkg::acc_state_t state_d;
   logic [UW-1:0] pre_q;
   logic [7:0] rate_q;
   logic [10:0] slp_q;
   logic [SW-1:0] settle_q;
   logic unit_tick;
   logic rate_tick;
   logic strobe;
   logic sleep_entry;
   logic [7:0] rate_units;
   acc_pkg::acc_sample_t smp;

   assign unit_tick = (pre_q == UW'(P_UNIT_CYC - 1));
   // Unfiltered every step (2 kHz), filtered every 2^(7-idx) steps
   assign rate_units = unfilt_q ? 8'h01 : (8'h01 << (3'h7 - bw_index(bw_q)));
   assign rate_tick = unit_tick && (rate_q >= rate_units - 8'h01);
   assign strobe = (state_q == acc_pkg::ACC_NORMAL) ? rate_tick : (state_q == acc_pkg::ACC_ACQ);
   assign smp = unfilt_q ? i_afe_raw : i_afe_filt;
   assign sleep_entry = (state_d == acc_pkg::ACC_SLEEP) && (state_q != acc_pkg::ACC_SLEEP);

   // Configuration registers
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         range_q <= `ACC_RANGE_RST;
         bw_q <= `ACC_BW_RST;
         lp_en_q <= 1'b0;
         sleep_code_q <= 4'h0;
         lp_var_q <= 1'b0;
         unfilt_q <= 1'b0;
         shdis_q <= 1'b0;
         st_q <= '0;
      end else if (i_reg_wr) begin
         if (i_reg_addr == `ACC_OFS_RANGE) begin
            range_q <= i_reg_wdata[3:0];
         end else if (i_reg_addr == `ACC_OFS_BW) begin
            bw_q <= i_reg_wdata[4:0];
         end else if (i_reg_addr == `ACC_OFS_LP_CTL) begin
            lp_en_q <= i_reg_wdata[`ACC_LP_EN_BIT];
            sleep_code_q <= i_reg_wdata[`ACC_SLEEP_HI:`ACC_SLEEP_LO];
         end else if (i_reg_addr == `ACC_OFS_LP_MODE) begin
            lp_var_q <= i_reg_wdata[`ACC_LP_VAR_BIT];
         end else if (i_reg_addr == `ACC_OFS_DATA_CTL) begin
            unfilt_q <= i_reg_wdata[`ACC_UNFILT_BIT];
            shdis_q <= i_reg_wdata[`ACC_SHDIS_BIT];
         end else if (i_reg_addr == `ACC_OFS_SELFTEST) begin
            st_q.axis <= i_reg_wdata[`ACC_ST_AXIS_HI:`ACC_ST_AXIS_LO];
            st_q.sign <= i_reg_wdata[`ACC_ST_SIGN_BIT];
            st_q.amp <= i_reg_wdata[`ACC_ST_AMP_BIT];
         end
      end
   end

   // Sample-rate time base; sleep starts on a fresh step so its length is exact
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || unit_tick || sleep_entry) begin
         pre_q <= '0;
      end else begin
         pre_q <= pre_q + UW'(1);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst || rate_tick) begin
         rate_q <= 8'h00;
      end else if (unit_tick) begin
         rate_q <= rate_q + 8'h01;
      end
   end

   // Power sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         acc_pkg::ACC_NORMAL: begin
            if (lp_en_q)
               state_d = acc_pkg::ACC_SLEEP;
         end
         acc_pkg::ACC_SLEEP: begin
            if (!lp_en_q)
               state_d = acc_pkg::ACC_NORMAL;
            else if (unit_tick && slp_q >= sleep_units(sleep_code_q) - 11'h001)
               state_d = acc_pkg::ACC_SETTLE;
         end
         acc_pkg::ACC_SETTLE: begin
            if (!lp_en_q)
               state_d = acc_pkg::ACC_NORMAL;
            else if (settle_q == SW'(P_SETTLE_CYC - 1))
               state_d = acc_pkg::ACC_ACQ;
         end
         acc_pkg::ACC_ACQ: begin
            state_d = lp_en_q ? acc_pkg::ACC_SLEEP : acc_pkg::ACC_NORMAL;
         end
         default: state_d = acc_pkg::ACC_NORMAL;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_q <= acc_pkg::ACC_NORMAL;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst || state_q != acc_pkg::ACC_SLEEP) begin
         slp_q <= 11'h000;
      end else if (unit_tick) begin
         slp_q <= slp_q + 11'h001;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst || state_q != acc_pkg::ACC_SETTLE) begin
         settle_q <= '0;
      end else begin
         settle_q <= settle_q + SW'(1);
      end
   end

   // Front-end controls
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_analog_pwr <= 1'b1;
         o_lp_variant <= 1'b0;
         o_range <= `ACC_RANGE_RST;
         o_bw_idx <= `ACC_BW_HIGH_IDX;
         o_selftest <= '0;
      end else begin
         o_analog_pwr <= (state_d != acc_pkg::ACC_SLEEP);
         o_lp_variant <= lp_var_q;
         o_range <= range_q;
         o_bw_idx <= bw_index(bw_q);
         o_selftest <= st_q;
      end
   end

   // Per-axis data registers with shadow lock
   for (genvar g = 0; g < 3; g++) begin : g_axis
      localparam logic [7:0] LSB_ADDR = `ACC_OFS_X_LSB + 8'(2 * g);
      localparam logic [7:0] MSB_ADDR = LSB_ADDR + 8'h01;
      logic [11:0] axis_smp;
      logic rd_lsb;
      logic rd_msb;
      assign axis_smp = smp[12*g +: 12];
      assign rd_lsb = i_reg_rd && (i_reg_addr == LSB_ADDR);
      assign rd_msb = i_reg_rd && (i_reg_addr == MSB_ADDR);

      always_ff @(posedge i_ref_clk) begin
         if (i_srst || shdis_q || rd_msb) begin
            lock_q[g] <= 1'b0;
         end else if (rd_lsb) begin
            lock_q[g] <= 1'b1;
         end
      end

      always_ff @(posedge i_ref_clk) begin
         if (i_srst) begin
            msb_q[g] <= 8'h00;
            lsb_q[g] <= 4'h0;
         end else if (strobe) begin
            lsb_q[g] <= axis_smp[3:0];
            if (!lock_q[g] || shdis_q)
               msb_q[g] <= axis_smp[11:4];
         end
      end

      always_ff @(posedge i_ref_clk) begin
         if (i_srst) begin
            new_q[g] <= 1'b0;
         end else if (strobe) begin
            new_q[g] <= 1'b1;
         end else if (rd_lsb || rd_msb) begin
            new_q[g] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         temp_q <= 8'h00;
      end else if (strobe) begin
         temp_q <= i_afe_temp;
      end
   end

   // Read path
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         if (i_reg_addr == `ACC_OFS_X_LSB)
            o_reg_rdata <= {lsb_q[0], 3'h0, new_q[0]};
         else if (i_reg_addr == `ACC_OFS_X_LSB + 8'h01)
            o_reg_rdata <= msb_q[0];
         else if (i_reg_addr == `ACC_OFS_X_LSB + 8'h02)
            o_reg_rdata <= {lsb_q[1], 3'h0, new_q[1]};
         else if (i_reg_addr == `ACC_OFS_X_LSB + 8'h03)
            o_reg_rdata <= msb_q[1];
         else if (i_reg_addr == `ACC_OFS_X_LSB + 8'h04)
            o_reg_rdata <= {lsb_q[2], 3'h0, new_q[2]};
         else if (i_reg_addr == `ACC_OFS_X_LSB + 8'h05)
            o_reg_rdata <= msb_q[2];
         else if (i_reg_addr == `ACC_OFS_TEMP)
            o_reg_rdata <= temp_q;
         else if (i_reg_addr == `ACC_OFS_RANGE)
            o_reg_rdata <= {4'h0, range_q};
         else if (i_reg_addr == `ACC_OFS_BW)
            o_reg_rdata <= {3'h0, bw_q};
         else if (i_reg_addr == `ACC_OFS_LP_CTL)
            o_reg_rdata <= {1'b0, lp_en_q, 1'b0, sleep_code_q, 1'b0};
         else if (i_reg_addr == `ACC_OFS_LP_MODE)
            o_reg_rdata <= {1'b0, lp_var_q, 6'h00};
         else if (i_reg_addr == `ACC_OFS_DATA_CTL)
            o_reg_rdata <= {unfilt_q, shdis_q, 6'h00};
         else if (i_reg_addr == `ACC_OFS_SELFTEST)
            o_reg_rdata <= {3'h0, st_q.amp, 1'b0, st_q.sign, st_q.axis};
         else
            o_reg_rdata <= 8'h00;
      end
   end

   // Checks
   sequence s_settle_done;
      state_q == acc_pkg::ACC_SETTLE && settle_q == SW'(P_SETTLE_CYC - 1) && lp_en_q;
   endsequence

   sequence s_acquire;
      state_q == acc_pkg::ACC_ACQ ##1 state_q == acc_pkg::ACC_SLEEP;
   endsequence

   new_flag_set_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      strobe |=> new_q[0] && new_q[1] && new_q[2])
      else $error("fresh flag not set by update");

   new_flag_clr_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (i_reg_rd && i_reg_addr == `ACC_OFS_X_LSB + 8'h01 && !strobe) |=> !new_q[0])
      else $error("fresh flag not cleared by read");

   shadow_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (lock_q[0] && !shdis_q) |=> $stable(msb_q[0]))
      else $error("locked upper byte changed");

   shadow_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (i_reg_rd && i_reg_addr == `ACC_OFS_X_LSB && !shdis_q) |=> lock_q[0])
      else $error("lower byte read did not lock");

   shadow_off_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (strobe && shdis_q && !unfilt_q) |=> msb_q[0] == $past(i_afe_filt.x[11:4]))
      else $error("upper byte not updated with shadowing off");

   sleep_power_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      state_q == acc_pkg::ACC_SLEEP |-> !o_analog_pwr)
      else $error("analog power on during sleep");

   settle_then_acq_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      s_settle_done |=> s_acquire)
      else $error("wake phase did not sample then sleep");

   bw_clamp_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (bw_q[4] |=> o_bw_idx == `ACC_BW_HIGH_IDX) and (bw_q[4:3] == 2'b00 |=> o_bw_idx == `ACC_BW_LOW_IDX))
      else $error("out-of-table bandwidth not clamped");

   selftest_ctl_a: assert property (@(posedge i_ref_clk) disable iff (i_srst)
      (i_reg_wr && i_reg_addr == `ACC_OFS_SELFTEST) |=> ##1
      o_selftest.axis == $past(i_reg_wdata[`ACC_ST_AXIS_HI:`ACC_ST_AXIS_LO], 2) &&
      o_selftest.sign == $past(i_reg_wdata[`ACC_ST_SIGN_BIT], 2))
      else $error("self-test controls not applied");

endmodule

`default_nettype wire

// file: bench/acc_host.sv
`timescale 1ns/1ps
`default_nettype none

module acc_host (
   // Clock
   input wire logic i_ref_clk,
   // Register port
   output logic [7:0] o_reg_addr,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [7:0] o_reg_wdata,
   input wire logic [7:0] i_reg_rdata
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
      o_reg_wdata = 8'h00;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_ref_clk);
      o_reg_addr <= a;
      o_reg_wdata <= v;
      o_reg_wr <= 1'b1;
      @(posedge i_ref_clk);
      o_reg_wr <= 1'b0;
      // Released data must not keep showing the last value
      o_reg_wdata <= ~v;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_ref_clk);
      o_reg_addr <= a;
      o_reg_rd <= 1'b1;
      @(posedge i_ref_clk);
      o_reg_rd <= 1'b0;
      // Registered answer stands from this edge on; take it at the next one
      @(posedge i_ref_clk);
      v = i_reg_rdata;
   endtask

   // Lower byte first, so the upper byte stays consistent with it
   task automatic rd_axis(input logic [1:0] ax, output logic [7:0] lo, output logic [7:0] hi);
      rd(8'h02 + {5'h00, ax, 1'b0}, lo);
      rd(8'h03 + {5'h00, ax, 1'b0}, hi);
   endtask

   task automatic st_prep();
      wr(8'h0F, 8'h08);
      wr(8'h32, 8'h10);
   endtask
endmodule

`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
   localparam int UNIT = 20;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [7:0] addr, wdata, rdata;
   logic wr, rd, pwr, lpv;
   acc_pkg::acc_sample_t filt = '0;
   acc_pkg::acc_sample_t raw = '0;
   logic [7:0] temp = 8'h00;
   logic [3:0] rng;
   logic [2:0] bwi;
   acc_pkg::acc_selftest_t st;
   int errors = 0;
   int check_count = 0;
   int cyc = 0;

   always #5 i_ref_clk = ~i_ref_clk;

   acc_host host (.i_ref_clk(i_ref_clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
      .o_reg_wdata(wdata), .i_reg_rdata(rdata));

   acc_readout #(.P_UNIT_CYC(UNIT), .P_SETTLE_CYC(4)) uut (.i_ref_clk(i_ref_clk),
      .i_srst(i_srst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .i_afe_filt(filt), .i_afe_raw(raw), .i_afe_temp(temp),
      .o_analog_pwr(pwr), .o_lp_variant(lpv), .o_range(rng), .o_bw_idx(bwi), .o_selftest(st));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic gap(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask

   // Poll y until a flagged sample arrives; each pair releases the lock
   task automatic fresh();
      logic [7:0] lo, hi;
      int i;
      lo = 8'h00;
      for (i = 0; i < 1500 && lo[0] !== 1'b1; i++) begin
         host.rd_axis(2'd1, lo, hi);
      end
   endtask

   task automatic t_reset();
      logic [7:0] d;
      host.rd(8'h0F, d);
      chk(d, 8'h03, "range reg");
      host.rd(8'h01, d);
      chk(d, 8'h00, "unmapped");
      chk({4'h0, rng}, 8'h03, "range out");
      chk({5'h00, bwi}, 8'h07, "bw out");
      chk({7'h00, pwr}, 8'h01, "power");
      $display("test reset done");
   endtask

   task automatic t_data();
      logic [7:0] lo, hi;
      @(posedge i_ref_clk);
      filt <= {12'h800, 12'h123, 12'hA5C};
      host.wr(8'h10, 8'h08);
      fresh();
      fresh();
      host.rd_axis(2'd0, lo, hi);
      chk(lo & 8'hF1, 8'hC1, "x lo");
      chk(hi, 8'hA5, "x hi");
      host.rd(8'h02, lo);
      chk(lo & 8'h01, 8'h00, "x flag");
      host.rd(8'h03, hi);
      host.rd_axis(2'd2, lo, hi);
      chk(lo & 8'hF1, 8'h01, "z lo");
      chk(hi, 8'h80, "z hi");
      host.rd_axis(2'd1, lo, hi);
      chk(lo & 8'hF1, 8'h30, "y lo");
      chk(hi, 8'h12, "y hi");
      host.wr(8'h10, 8'h0F);
      $display("test data done");
   endtask

   task automatic t_shadow();
      logic [7:0] lo, hi;
      @(posedge i_ref_clk);
      filt <= {24'h000000, 12'h111};
      gap(50);
      host.rd(8'h02, lo);
      filt <= {24'h000000, 12'h222};
      gap(50);
      host.rd(8'h03, hi);
      chk(hi, 8'h11, "locked hi");
      gap(50);
      host.rd_axis(2'd0, lo, hi);
      chk(hi, 8'h22, "released hi");
      host.wr(8'h13, 8'h40);
      host.rd(8'h02, lo);
      filt <= {24'h000000, 12'h333};
      gap(50);
      host.rd(8'h03, hi);
      chk(hi, 8'h33, "unlocked hi");
      host.wr(8'h13, 8'h00);
      $display("test shadow done");
   endtask

   task automatic t_select();
      logic [7:0] lo, hi;
      @(posedge i_ref_clk);
      filt <= {24'h000000, 12'h444};
      raw <= {24'h000000, 12'h555};
      temp <= 8'hF6;
      host.wr(8'h13, 8'h80);
      gap(50);
      host.rd_axis(2'd0, lo, hi);
      chk(hi, 8'h55, "raw hi");
      host.rd(8'h08, lo);
      chk(lo, 8'hF6, "temp");
      host.wr(8'h13, 8'h00);
      gap(50);
      host.rd_axis(2'd0, lo, hi);
      chk(hi, 8'h44, "filt hi");
      $display("test select done");
   endtask

   task automatic t_config();
      logic [4:0] bc [12] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
         5'h0E, 5'h0F, 5'h10, 5'h1F};
      logic [3:0] rc [4] = '{4'h5, 4'h8, 4'hC, 4'h3};
      logic [2:0] e;
      int i;
      for (i = 0; i < 12; i++) begin
         host.wr(8'h10, {3'h0, bc[i]});
         gap(3);
         e = bc[i][4] ? 3'h7 : (bc[i][3] ? bc[i][2:0] : 3'h0);
         chk({5'h00, bwi}, {5'h00, e}, "bw idx");
      end
      for (i = 0; i < 4; i++) begin
         host.wr(8'h0F, {4'h0, rc[i]});
         gap(3);
         chk({4'h0, rng}, {4'h0, rc[i]}, "range");
      end
      host.st_prep();
      for (i = 0; i < 8; i++) begin
         host.wr(8'h32, {5'h02, i[2:0]});
         gap(3);
         chk({4'h0, st}, {5'h01, i[2:0]}, "selftest");
      end
      // Settling time of 50 ms in scaled steps
      gap(100 * UNIT);
      host.wr(8'h32, 8'h00);
      gap(100 * UNIT);
      host.wr(8'h0F, 8'h03);
      $display("test config done");
   endtask

   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (pwr === lvl && n < 2000) begin
         @(posedge i_ref_clk);
         #1;
         n++;
      end
   endtask

   task automatic t_lowpow();
      logic [3:0] sc [2] = '{4'h0, 4'h6};
      int el [2] = '{1, 2};
      int k, n;
      host.wr(8'h12, 8'h40);
      gap(3);
      chk({7'h00, lpv}, 8'h01, "variant");
      for (k = 0; k < 2; k++) begin
         host.wr(8'h11, {3'h2, sc[k], 1'b0});
         run_len(1'b1, n);
         run_len(1'b0, n);
         chk(8'(n), 8'(UNIT * el[k]), "sleep len");
         run_len(1'b1, n);
         chk(8'(n), 8'h05, "wake len");
         host.wr(8'h11, 8'h00);
         gap(3);
         chk({7'h00, pwr}, 8'h01, "lp exit");
      end
      host.wr(8'h12, 8'h00);
      $display("test lowpow done");
   endtask

   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         $display("ERROR %0t timeout", $time);
         summarize();
      end
   end

   initial begin
      gap(6);
      i_srst <= 1'b0;
      t_reset();
      t_data();
      t_shadow();
      t_select();
      t_config();
      t_lowpow();
      summarize();
   end
endmodule

`default_nettype wire
